// file: core/bfl_core.sv
// execution slice for branch-on-interrupt-flag, bit, shift, flag and pointer-load instructions
`default_nettype none
// Functional notes
// - branch on interrupt enabled adds offset plus one to pc; 1 cycle untaken, 2 taken.
// - branch on interrupt disabled does the same when the flag is zero.
// - io bit set forces one io register bit high in two cycles, flags kept.
// - io bit clear forces one io register bit low in two cycles, flags kept.
// - logical left shift, zero into bit 0, updates Z C N V, one cycle.
// - logical right shift, zero into bit 7, updates Z C N V, one cycle.
// - rotate left through carry, old bit 7 to carry, one cycle.
// - rotate right through carry, old bit 0 to carry, one cycle.
// - arithmetic right shift keeps bit 7, updates Z C N V, one cycle.
// - copy a chosen register bit into T, only T changes, one cycle.
// - copy T into a chosen register bit, no flag changes, one cycle.
// - one-cycle set or clear of the signed test flag alone.
// - one-cycle set or clear of the overflow flag alone.
// - one-cycle set or clear of any single status flag, others untouched.
// - post-increment load reads at pointer then adds one; two cycles.
// - pre-decrement load subtracts one then reads; two cycles, no flags.
// - displacement load reads at pointer plus unsigned offset, pointer unchanged.
module bfl_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [bfl_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic busy_o
);
  import bfl_pkg::*;

  logic [7:0] rf_q [N_REGS];
  logic [7:0] io_q [N_IO];
  logic [7:0] mem_q [N_MEM];
  logic [7:0] flags_q;
  logic [15:0] pc_q;
  logic [31:0] ir_q;
  logic [1:0] last_q;
  logic busy_q;
  bfl_state_e st_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic req, wr_idle, start, rf_hit, io_hit, mem_hit;
  logic [11:0] rf_off, io_off, mem_off;
  logic [4:0] rf_idx;
  logic [2:0] io_idx;
  logic [5:0] mem_idx;

  // one request per ack; state writes made while the slice is busy are acked but dropped
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_idle = req & wb_we_i & wb_sel_i[0] & (st_q == ST_IDLE);
  assign start = wr_idle & (wb_sel_i == SEL_WORD) & (wb_adr_i == ADR_INSTR);
  assign rf_off = wb_adr_i - ADR_RF_BASE;
  assign io_off = wb_adr_i - ADR_IO_BASE;
  assign mem_off = wb_adr_i - ADR_MEM_BASE;
  assign rf_hit = (wb_adr_i & ~RF_SPAN_MASK) == ADR_RF_BASE;
  assign io_hit = (wb_adr_i & ~IO_SPAN_MASK) == ADR_IO_BASE;
  assign mem_hit = (wb_adr_i & ~MEM_SPAN_MASK) == ADR_MEM_BASE;
  assign rf_idx = rf_off[ADR_WORD_LSB +: 5];
  assign io_idx = io_off[ADR_WORD_LSB +: 3];
  assign mem_idx = mem_off[ADR_WORD_LSB +: MEM_AW];

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  bfl_op_t op;
  logic [4:0] rd, rr, pbase;
  logic [2:0] bsel;
  logic [1:0] psel, mode;
  logic [7:0] imm, rd_v, rr_v, ld_data, sh_res;
  logic [15:0] ptr, ea, pnew, koff;
  logic taken, two, commit1, commit2;
  logic sh_hit, sh_c, sh_z, sh_n, sh_v;

  assign op = ir_q[F_OP_LSB +: 5];
  assign rd = ir_q[F_RD_LSB +: 5];
  assign rr = ir_q[F_RR_LSB +: 5];
  assign bsel = ir_q[F_BIT_LSB +: 3];
  assign psel = ir_q[F_PTR_LSB +: 2];
  assign mode = ir_q[F_MODE_LSB +: 2];
  assign imm = ir_q[7:0];
  assign rd_v = rf_q[rd];
  assign rr_v = rf_q[rr];
  assign pbase = PTR_X_LO + {2'h0, psel, 1'h0};
  assign ptr = {rf_q[pbase + 5'h01], rf_q[pbase]};

  // effective address; the pre-decrement address is also the new pointer
  always_comb begin
    case (mode)
      LD_PRE: ea = ptr - 16'h0001;
      LD_DISP: ea = ptr + {10'h000, imm[5:0]};
      default: ea = ptr;
    endcase
  end

  assign pnew = (mode == LD_PRE) ? ea : ptr + 16'h0001;
  assign ld_data = mem_q[ea[MEM_AW-1:0]];
  assign koff = {{9{imm[6]}}, imm[6:0]};

  // the interrupt flag cannot move during the instruction, so taken is stable
  assign taken = (op == OP_BR_IRQ_EN && flags_q[FLG_I]) ||
                 (op == OP_BR_IRQ_DIS && !flags_q[FLG_I]);
  assign two = taken || op == OP_IO_SET || op == OP_IO_CLR || op == OP_PTR_LOAD;
  assign commit1 = (st_q == ST_EX1) && !two;
  assign commit2 = (st_q == ST_EX2);

  bfl_shift u_shift (
    .op_i(op),
    .val_i(rd_v),
    .carry_i(flags_q[FLG_C]),
    .hit_o(sh_hit),
    .res_o(sh_res),
    .c_o(sh_c),
    .z_o(sh_z),
    .n_o(sh_n),
    .v_o(sh_v)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // one execute cycle, or two for taken branches, io bit ops and pointer loads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      ir_q <= IR_RST;
      last_q <= 2'h0;
      busy_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            ir_q <= wb_dat_i;
            st_q <= ST_EX1;
            busy_q <= 1'b1;
          end
        end
        ST_EX1: begin
          if (two) begin
            st_q <= ST_EX2;
          end else begin
            st_q <= ST_IDLE;
            last_q <= CYC_ONE;
            busy_q <= 1'b0;
          end
        end
        ST_EX2: begin
          st_q <= ST_IDLE;
          last_q <= CYC_TWO;
          busy_q <= 1'b0;
        end
        default: begin
          st_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // program counter: relative step when taken, else next word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q <= PC_RST;
    end else if (wr_idle && wb_sel_i[1] && wb_adr_i == ADR_PC) begin
      pc_q <= wb_dat_i[15:0];
    end else if (commit1 || commit2) begin
      pc_q <= taken ? pc_q + koff + 16'h0001 : pc_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= FLAGS_RST;
    end else if (wr_idle && wb_adr_i == ADR_FLAGS) begin
      flags_q <= wb_dat_i[7:0];
    end else if (commit1) begin
      case (op)
        OP_FLAG_SET: flags_q[bsel] <= 1'b1;
        OP_FLAG_CLR: flags_q[bsel] <= 1'b0;
        OP_BIT_TO_T: flags_q[FLG_T] <= rr_v[bsel];
        default: begin
          if (sh_hit) begin
            flags_q[FLG_C] <= sh_c;
            flags_q[FLG_Z] <= sh_z;
            flags_q[FLG_N] <= sh_n;
            flags_q[FLG_V] <= sh_v;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register file, io registers, data memory
  // ----------------------------------------------------------------
  // a load whose target is its own pointer ends with the loaded byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N_REGS; i++) begin
        rf_q[i] <= 8'h00;
      end
    end else if (wr_idle && rf_hit) begin
      rf_q[rf_idx] <= wb_dat_i[7:0];
    end else if (commit1) begin
      if (sh_hit) begin
        rf_q[rd] <= sh_res;
      end else begin
        case (op)
          OP_NIB_SWAP: rf_q[rd] <= {rd_v[3:0], rd_v[7:4]};
          OP_T_TO_BIT: rf_q[rd][bsel] <= flags_q[FLG_T];
          OP_REG_MOVE: rf_q[rd] <= rr_v;
          OP_IMM_LOAD: rf_q[rd] <= imm;
          OP_PAIR_COPY: begin
            rf_q[{rd[4:1], 1'b0}] <= rf_q[{rr[4:1], 1'b0}];
            rf_q[{rd[4:1], 1'b1}] <= rf_q[{rr[4:1], 1'b1}];
          end
          default: begin
          end
        endcase
      end
    end else if (commit2 && op == OP_PTR_LOAD) begin
      if (mode == LD_POST || mode == LD_PRE) begin
        rf_q[pbase] <= pnew[7:0];
        rf_q[pbase + 5'h01] <= pnew[15:8];
      end
      rf_q[rd] <= ld_data;
    end
  end

  // io bit ops commit in the second cycle, as a read-modify-write would
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N_IO; i++) begin
        io_q[i] <= 8'h00;
      end
    end else if (wr_idle && io_hit) begin
      io_q[io_idx] <= wb_dat_i[7:0];
    end else if (commit2 && op == OP_IO_SET) begin
      io_q[imm[2:0]][bsel] <= 1'b1;
    end else if (commit2 && op == OP_IO_CLR) begin
      io_q[imm[2:0]][bsel] <= 1'b0;
    end
  end

  // data memory is written only from the bus; no reset, like a ram
  always_ff @(posedge clk_i) begin
    if (wr_idle && mem_hit) begin
      mem_q[mem_idx] <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (rf_hit) begin
      rd_mux[7:0] = rf_q[rf_idx];
    end else if (io_hit) begin
      rd_mux[7:0] = io_q[io_idx];
    end else if (mem_hit) begin
      rd_mux[7:0] = mem_q[mem_idx];
    end else begin
      case (wb_adr_i)
        ADR_INSTR: rd_mux = ir_q;
        ADR_STATUS: begin
          rd_mux[7:0] = flags_q;
          rd_mux[ST_BUSY_BIT] = busy_q;
          rd_mux[ST_CYC_LSB +: 2] = last_q;
        end
        ADR_PC: rd_mux[15:0] = pc_q;
        ADR_FLAGS: rd_mux[7:0] = flags_q;
        default: rd_mux = 32'h0000_0000; // unmapped reads zero, still acked
      endcase
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req) begin
        rdat_q <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign busy_o = busy_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_br_irq_en: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_EX1 && op == OP_BR_IRQ_EN && flags_q[FLG_I] |=> st_q == ST_EX2 ##1
    (st_q == ST_IDLE && last_q == CYC_TWO && pc_q == $past(pc_q, 2) + koff + 16'h0001))
    else $error("taken branch on enabled interrupts wrong");
  a_br_irq_dis: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_EX1 && op == OP_BR_IRQ_DIS && flags_q[FLG_I] |=>
    st_q == ST_IDLE && last_q == CYC_ONE && pc_q == $past(pc_q) + 16'h0001)
    else $error("untaken branch on disabled interrupts wrong");
  a_io_bit_set: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_EX1 && op == OP_IO_SET |-> ##2
    (io_q[imm[2:0]] == ($past(io_q[imm[2:0]], 2) | (8'h01 << bsel)) && flags_q == $past(flags_q, 2)))
    else $error("io bit set wrong");
  a_io_bit_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_EX1 && op == OP_IO_CLR |-> ##2
    (io_q[imm[2:0]] == ($past(io_q[imm[2:0]], 2) & ~(8'h01 << bsel)) && last_q == CYC_TWO))
    else $error("io bit clear wrong");
  a_shift_left: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_EX1 && op == OP_SHIFT_LEFT |=>
    rf_q[rd] == {$past(rd_v[6:0]), 1'b0} && flags_q[FLG_C] == $past(rd_v[7]))
    else $error("left shift wrong");
  a_rot_left: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_EX1 && op == OP_ROT_LEFT |=>
    rf_q[rd] == {$past(rd_v[6:0]), $past(flags_q[FLG_C])} && flags_q[FLG_C] == $past(rd_v[7]))
    else $error("rotate left wrong");
  a_shift_arith: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_EX1 && op == OP_SHIFT_ARITH |=>
    rf_q[rd] == {$past(rd_v[7]), $past(rd_v[7:1])} && flags_q[FLG_C] == $past(rd_v[0]))
    else $error("arithmetic shift wrong");
  a_bit_to_t: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_EX1 && op == OP_BIT_TO_T |=> flags_q[FLG_T] == $past(rr_v[bsel]) &&
    ((flags_q ^ $past(flags_q)) & ~(8'h01 << FLG_T)) == 8'h00)
    else $error("bit to t wrong");
  a_flag_only: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_EX1 && op == OP_FLAG_SET |=> flags_q == ($past(flags_q) | (8'h01 << bsel)))
    else $error("single flag set disturbed others");
  a_ptr_post: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_EX1 && op == OP_PTR_LOAD && mode == LD_POST && rd[4:1] != pbase[4:1] |-> ##2
    (ptr == $past(ptr, 2) + 16'h0001 && rf_q[rd] == $past(ld_data)))
    else $error("post-increment load wrong");
  a_ptr_pre: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_EX1 && op == OP_PTR_LOAD && mode == LD_PRE && rd[4:1] != pbase[4:1] |-> ##2
    (ptr == $past(ptr, 2) - 16'h0001 && rf_q[rd] == $past(ld_data)))
    else $error("pre-decrement load wrong");
  a_nib_swap: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_EX1 && op == OP_NIB_SWAP |=>
    rf_q[rd] == {$past(rd_v[3:0]), $past(rd_v[7:4])} && $stable(flags_q))
    else $error("nibble swap wrong");
endmodule
`default_nettype wire

// file: core/bfl_pkg.sv
// shared constants and types for the bit, flag and pointer-load execution slice
`default_nettype none
package bfl_pkg;
  // ----------------------------------------------------------------
  // bus map
  // ----------------------------------------------------------------
  localparam int WB_AW = 12;
  localparam int ADR_WORD_LSB = 2;
  localparam logic [11:0] ADR_INSTR = 12'h000;
  localparam logic [11:0] ADR_STATUS = 12'h004;
  localparam logic [11:0] ADR_PC = 12'h008;
  localparam logic [11:0] ADR_FLAGS = 12'h00C;
  localparam logic [11:0] ADR_RF_BASE = 12'h080;
  localparam logic [11:0] ADR_IO_BASE = 12'h100;
  localparam logic [11:0] ADR_MEM_BASE = 12'h200;
  localparam logic [11:0] RF_SPAN_MASK = 12'h07F;
  localparam logic [11:0] IO_SPAN_MASK = 12'h01F;
  localparam logic [11:0] MEM_SPAN_MASK = 12'h0FF;
  localparam logic [3:0] SEL_WORD = 4'hF;
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_CYC_LSB = 9;

  // ----------------------------------------------------------------
  // storage sizes and reset values
  // ----------------------------------------------------------------
  localparam int N_REGS = 32;
  localparam int N_IO = 8;
  localparam int MEM_AW = 6;
  localparam int N_MEM = 64;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [31:0] IR_RST = 32'h0000_0000;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // ----------------------------------------------------------------
  // instruction word fields and status flag positions
  // ----------------------------------------------------------------
  localparam int F_OP_LSB = 27;
  localparam int F_RD_LSB = 22;
  localparam int F_RR_LSB = 17;
  localparam int F_BIT_LSB = 14;
  localparam int F_PTR_LSB = 12;
  localparam int F_MODE_LSB = 10;
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;

  // ----------------------------------------------------------------
  // opcodes, pointer bases, load modes, states
  // ----------------------------------------------------------------
  typedef logic [4:0] bfl_op_t;
  localparam bfl_op_t OP_NOP = 5'h00;
  localparam bfl_op_t OP_BR_IRQ_EN = 5'h01;
  localparam bfl_op_t OP_BR_IRQ_DIS = 5'h02;
  localparam bfl_op_t OP_IO_SET = 5'h03;
  localparam bfl_op_t OP_IO_CLR = 5'h04;
  localparam bfl_op_t OP_SHIFT_LEFT = 5'h05;
  localparam bfl_op_t OP_SHIFT_RIGHT = 5'h06;
  localparam bfl_op_t OP_ROT_LEFT = 5'h07;
  localparam bfl_op_t OP_ROT_RIGHT = 5'h08;
  localparam bfl_op_t OP_SHIFT_ARITH = 5'h09;
  localparam bfl_op_t OP_NIB_SWAP = 5'h0A;
  localparam bfl_op_t OP_FLAG_SET = 5'h0B;
  localparam bfl_op_t OP_FLAG_CLR = 5'h0C;
  localparam bfl_op_t OP_BIT_TO_T = 5'h0D;
  localparam bfl_op_t OP_T_TO_BIT = 5'h0E;
  localparam bfl_op_t OP_REG_MOVE = 5'h0F;
  localparam bfl_op_t OP_PAIR_COPY = 5'h10;
  localparam bfl_op_t OP_IMM_LOAD = 5'h11;
  localparam bfl_op_t OP_PTR_LOAD = 5'h12;
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [1:0] LD_PLAIN = 2'h0;
  localparam logic [1:0] LD_POST = 2'h1;
  localparam logic [1:0] LD_PRE = 2'h2;
  localparam logic [1:0] LD_DISP = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_EX1, ST_EX2} bfl_state_e;
endpackage
`default_nettype wire

// file: core/bfl_shift.sv
// shift and rotate unit with its flag results
`default_nettype none
module bfl_shift (
  input wire bfl_pkg::bfl_op_t op_i,
  input wire logic [7:0] val_i,
  input wire logic carry_i,
  output logic hit_o,
  output logic [7:0] res_o,
  output logic c_o,
  output logic z_o,
  output logic n_o,
  output logic v_o
);
  import bfl_pkg::*;

  // one result path per shift kind; hit_o tells the core the op is ours
  always_comb begin
    hit_o = 1'b1;
    res_o = val_i;
    c_o = carry_i;
    case (op_i)
      OP_SHIFT_LEFT: begin
        res_o = {val_i[6:0], 1'b0};
        c_o = val_i[7];
      end
      OP_SHIFT_RIGHT: begin
        res_o = {1'b0, val_i[7:1]};
        c_o = val_i[0];
      end
      OP_ROT_LEFT: begin
        res_o = {val_i[6:0], carry_i};
        c_o = val_i[7];
      end
      OP_ROT_RIGHT: begin
        res_o = {carry_i, val_i[7:1]};
        c_o = val_i[0];
      end
      OP_SHIFT_ARITH: begin
        res_o = {val_i[7], val_i[7:1]};
        c_o = val_i[0];
      end
      default: begin
        hit_o = 1'b0;
      end
    endcase
  end

  // overflow is sign xor carry, as for any one-place shift
  assign z_o = (res_o == 8'h00);
  assign n_o = res_o[7];
  assign v_o = n_o ^ c_o;
endmodule
`default_nettype wire

// file: tb/bfl_host.sv
// wishbone master model standing in for the software that drives the slice
`default_nettype none
module bfl_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [11:0] adr_o,
  output logic [31:0] dat_o,
  output logic [3:0] sel_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // idle bus at time zero
  // ----------------------------------------------------------------
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 12'h000;
    dat_o = 32'h0000_0000;
    sel_o = 4'hF;
  end

  // ----------------------------------------------------------------
  // one classic cycle; the leading edge keeps cyc low a cycle between calls
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    // no answer time is assumed; the bench watchdog ends a dead wait
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/bfl_core_test.sv
// self-checking bench for the bit, flag, shift and pointer-load slice
`default_nettype none
module bfl_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  import bfl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, busy;
  logic [11:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  int checks = 0;
  int miscompares = 0;
  logic [15:0] ex;
  logic [7:0] sv [3] = '{8'h80, 8'h01, 8'hC3};

  always #2 clk_i = ~clk_i;

  bfl_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_ack_o(ack), .wb_dat_o(rdat), .busy_o(busy));
  bfl_host u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .dat_o(wdat), .sel_o(sel));

  // ----------------------------------------------------------------
  // access and compare helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rv(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_host.xfer(1'b0, a, 32'h0, q);
    checks++;
    if (q !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, q);
    end
  endtask
  // status word: flags, busy low, cycle count of the last instruction
  task automatic st(input logic [1:0] c, input logic [7:0] f);
    rv("status", ADR_STATUS, {21'h0, c, 1'b0, f});
  endtask
  function automatic logic [11:0] ra(input int n);
    return ADR_RF_BASE + 12'(4 * n);
  endfunction
  function automatic logic [31:0] ins(input bfl_op_t op, input int d, input int r, input int b, input int p,
      input int m, input int k);
    return {op, 5'(d), 5'(r), 3'(b), 2'(p), 2'(m), 2'h0, 8'(k)};
  endfunction
  // start one instruction and wait for busy to drop; a stuck busy falls to the watchdog
  task automatic exec(input logic [31:0] w);
    wr(ADR_INSTR, w);
    do begin
      @(posedge clk_i);
    end while (busy !== 1'b0);
  endtask
  // expected shift result over preset flags 0xF0 plus carry in
  function automatic logic [15:0] shx(input bfl_op_t op, input logic [7:0] v, input logic c);
    logic [7:0] r;
    logic co;
    case (op)
      OP_SHIFT_LEFT: r = {v[6:0], 1'b0};
      OP_SHIFT_RIGHT: r = {1'b0, v[7:1]};
      OP_ROT_LEFT: r = {v[6:0], c};
      OP_ROT_RIGHT: r = {c, v[7:1]};
      default: r = {v[7], v[7:1]};
    endcase
    // left moves push out bit 7, right moves push out bit 0
    co = (op == OP_SHIFT_LEFT || op == OP_ROT_LEFT) ? v[7] : v[0];
    return {r, 4'hF, r[7] ^ co, r[7], r == 8'h00, co};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rv("pc", ADR_PC, 32'h0);
    st(2'h0, 8'h00);
    rv("unmapped", 12'h7F0, 32'h0);
    wr(ADR_STATUS, 32'hFF);
    st(2'h0, 8'h00);
    // branches on the interrupt flag, taken and untaken, with wrap
    wr(ADR_FLAGS, 32'h80);
    exec(ins(OP_BR_IRQ_EN, 0, 0, 0, 0, 0, 8'h7D));
    rv("pc", ADR_PC, 32'hFFFE);
    st(CYC_TWO, 8'h80);
    exec(ins(OP_BR_IRQ_DIS, 0, 0, 0, 0, 0, 8'h05));
    rv("pc", ADR_PC, 32'hFFFF);
    st(CYC_ONE, 8'h80);
    wr(ADR_FLAGS, 32'h00);
    exec(ins(OP_BR_IRQ_DIS, 0, 0, 0, 0, 0, 8'h05));
    rv("pc", ADR_PC, 32'h0005);
    st(CYC_TWO, 8'h00);
    exec(ins(OP_BR_IRQ_EN, 0, 0, 0, 0, 0, 8'h05));
    rv("pc", ADR_PC, 32'h0006);
    st(CYC_ONE, 8'h00);
    // io bit set and clear on io register 3
    wr(ADR_IO_BASE + 12'h00C, 32'h5A);
    wr(ADR_FLAGS, 32'h21);
    exec(ins(OP_IO_SET, 0, 0, 0, 0, 0, 3));
    rv("io", ADR_IO_BASE + 12'h00C, 32'h5B);
    st(CYC_TWO, 8'h21);
    exec(ins(OP_IO_CLR, 0, 0, 6, 0, 0, 3));
    rv("io", ADR_IO_BASE + 12'h00C, 32'h1B);
    st(CYC_TWO, 8'h21);
    // every shift and rotate over edge values and both carries
    for (int op = 5; op <= 9; op++) begin
      for (int i = 0; i < 3; i++) begin
        ex = shx(bfl_op_t'(op), sv[i], i[0]);
        wr(ra(5), {24'h0, sv[i]});
        wr(ADR_FLAGS, {24'h0, 7'h78, i[0]});
        exec(ins(bfl_op_t'(op), 5, 0, 0, 0, 0, 0));
        rv("shift", ra(5), {24'h0, ex[15:8]});
        st(CYC_ONE, ex[7:0]);
      end
    end
    // single flag set then clear, one index at a time
    wr(ADR_FLAGS, 32'h00);
    for (int i = 0; i < 8; i++) begin
      exec(ins(OP_FLAG_SET, 0, 0, i, 0, 0, 0));
      st(CYC_ONE, 8'((16'h1 << (i + 1)) - 1));
    end
    for (int i = 0; i < 8; i++) begin
      exec(ins(OP_FLAG_CLR, 0, 0, i, 0, 0, 0));
      st(CYC_ONE, 8'(8'hFF << (i + 1)));
    end
    // bit transfer through T
    wr(ADR_FLAGS, 32'h0F);
    wr(ra(4), 32'h08);
    wr(ra(5), 32'h81);
    exec(ins(OP_BIT_TO_T, 0, 4, 3, 0, 0, 0));
    st(CYC_ONE, 8'h4F);
    exec(ins(OP_T_TO_BIT, 5, 0, 6, 0, 0, 0));
    rv("r5", ra(5), 32'hC1);
    st(CYC_ONE, 8'h4F);
    exec(ins(OP_BIT_TO_T, 0, 4, 2, 0, 0, 0));
    st(CYC_ONE, 8'h0F);
    // swap, immediate, move and pair copy
    wr(ra(6), 32'h3C);
    exec(ins(OP_NIB_SWAP, 6, 0, 0, 0, 0, 0));
    rv("r6", ra(6), 32'hC3);
    exec(ins(OP_IMM_LOAD, 7, 0, 0, 0, 0, 8'h9E));
    rv("r7", ra(7), 32'h9E);
    exec(ins(OP_REG_MOVE, 10, 6, 0, 0, 0, 0));
    rv("r10", ra(10), 32'hC3);
    exec(ins(OP_PAIR_COPY, 8, 6, 0, 0, 0, 0));
    rv("r8", ra(8), 32'hC3);
    rv("r9", ra(9), 32'h9E);
    st(CYC_ONE, 8'h0F);
    // pointer loads: X post-inc, Y pre-dec, Z displacement
    wr(ADR_MEM_BASE + 12'h040, 32'hA5);
    wr(ADR_MEM_BASE + 12'h044, 32'h3C);
    wr(ra(26), 32'h10);
    wr(ra(27), 32'h00);
    wr(ra(28), 32'h12);
    wr(ra(29), 32'h00);
    wr(ra(30), 32'h0E);
    wr(ra(31), 32'h00);
    exec(ins(OP_PTR_LOAD, 1, 0, 0, 0, LD_POST, 0));
    rv("r1", ra(1), 32'hA5);
    rv("x lo", ra(26), 32'h11);
    st(CYC_TWO, 8'h0F);
    exec(ins(OP_PTR_LOAD, 2, 0, 0, 1, LD_PRE, 0));
    rv("r2", ra(2), 32'h3C);
    rv("y lo", ra(28), 32'h11);
    st(CYC_TWO, 8'h0F);
    exec(ins(OP_PTR_LOAD, 3, 0, 0, 2, LD_DISP, 2));
    rv("r3", ra(3), 32'hA5);
    rv("z lo", ra(30), 32'h0E);
    st(CYC_TWO, 8'h0F);
    end_sim();
  end

  // ----------------------------------------------------------------
  // watchdog, well beyond the several hundred cycles the tests need
  // ----------------------------------------------------------------
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
